// file: dv/bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master (
    // bus lines
    output logic     scl,
    output logic     sda_low,
    input wire logic sda
);
    // idle bus: clock stands high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start();
        sda_low = 1'b0;
        #16 scl = 1'b1;
        #16 sda_low = 1'b1;
        #16 scl = 1'b0;
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        #16 scl = 1'b1;
        #16 sda_low = 1'b0;
        #16;
    endtask : stop
    // data moves only with the clock low; sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        #16 sda_low = !b;
        #16 scl = 1'b1;
        #16 s = sda;
        #16 scl = 1'b0;
    endtask : bit_io
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask : wbyte
    task automatic rbyte(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nack, s);
    endtask : rbyte
endmodule : bus_master
`default_nettype wire

// file: dv/serial_eeprom_target_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_target_tb;
    import eeprom_pkg::*;
    localparam logic [2:0] SEL = 3'h5;
    logic       clk, reset, scl, sda_low, sda, sda_out, sda_oe, write_busy;
    logic [2:0] sel;
    int         n_errors, comparisons;
    int         cycles = 0;
    // open-drain wire with pull-up
    assign sda = !(sda_low || (sda_oe && !sda_out));
    bus_master i_bus_master (.scl(scl), .sda_low(sda_low), .sda(sda));
    serial_eeprom_target #(.SIZE(SIZE_2K), .WRITE_CYCLES(200)) i_serial_eeprom_target (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .select_pin_high(sel[2]), .select_pin_mid(sel[1]),
        .select_pin_low(sel[0]), .write_busy(write_busy));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic addr_phase(input logic [7:0] a);
        logic k;
        i_bus_master.start();
        i_bus_master.wbyte({DEV_TYPE, SEL, 1'b0}, k);
        check("dev ack", k, 8'h00);
        i_bus_master.wbyte(a, k);
        check("addr ack", k, 8'h00);
    endtask : addr_phase
    task automatic read_bytes(input bit rnd, input logic [7:0] a, input logic [7:0] exp [$]);
        logic       k;
        logic [7:0] d;
        if (rnd) addr_phase(a);
        i_bus_master.start();
        i_bus_master.wbyte({DEV_TYPE, SEL, 1'b1}, k);
        check("rd ack", k, 8'h00);
        foreach (exp[i]) begin
            i_bus_master.rbyte(d, i == exp.size() - 1);
            check("rd data", d, exp[i]);
        end
        i_bus_master.stop();
    endtask : read_bytes
    // bounded wait: a stuck busy flag must not hang the run
    task automatic wait_write();
        int t;
        t = 0;
        #20;
        check("busy", write_busy, 8'h01);
        while (write_busy === 1'b1 && t < 400) begin
            @(posedge clk);
            t++;
        end
        @(negedge clk);
        check("busy done", write_busy, 8'h00);
    endtask : wait_write
    task automatic t_select();
        logic k;
        i_bus_master.start();
        i_bus_master.wbyte({DEV_TYPE, 3'h4, 1'b0}, k);
        check("sel nack", k, 8'h01);
        i_bus_master.start();
        i_bus_master.wbyte({4'h5, SEL, 1'b0}, k);
        check("type nack", k, 8'h01);
        i_bus_master.stop();
        check("released", sda_oe, 8'h00);
    endtask : t_select
    // ten bytes into an eight-byte page: last two wrap over the first two
    task automatic t_page();
        logic k;
        addr_phase(8'h16);
        for (int i = 0; i < 10; i++) begin
            i_bus_master.wbyte(8'h40 + 8'(i), k);
            check("data ack", k, 8'h00);
        end
        i_bus_master.stop();
        #20;
        i_bus_master.start();
        i_bus_master.wbyte({DEV_TYPE, SEL, 1'b0}, k);
        check("poll nack", k, 8'h01);
        i_bus_master.stop();
        wait_write();
        read_bytes(1, 8'h10, '{8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49});
        read_bytes(1, 8'h14, '{8'h46});
        read_bytes(0, 8'h00, '{8'h47});
    endtask : t_page
    task automatic t_wrap();
        logic k;
        addr_phase(8'h00);
        i_bus_master.wbyte(8'h5a, k);
        check("byte ack", k, 8'h00);
        i_bus_master.stop();
        wait_write();
        read_bytes(1, 8'hff, '{8'hff, 8'h5a});
    endtask : t_wrap
    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    initial begin
        reset = 1'b1;
        sel = SEL;
        n_errors = 0;
        comparisons = 0;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        t_select();
        t_page();
        t_wrap();
        finish_test();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
endmodule : serial_eeprom_target_tb
`default_nettype wire

// file: hw/eeprom_array.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_array (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // write port
    input  wire logic                          we,
    input  wire logic [eeprom_pkg::ADDR_W-1:0] waddr,
    input  wire logic [eeprom_pkg::DATA_W-1:0] wdata,
    // read port
    input  wire logic [eeprom_pkg::ADDR_W-1:0] raddr,
    output logic      [eeprom_pkg::DATA_W-1:0] rdata
);
    import eeprom_pkg::*;

    typedef struct packed {
        logic [ARRAY_BYTES-1:0][DATA_W-1:0] mem;
    } array_s;

    array_s s_r;
    array_s s_nxt;

    assign rdata = s_r.mem[raddr];

    always_comb begin
        s_nxt = s_r;
        if (we) begin
            s_nxt.mem[waddr] = wdata;
        end
    end

    // reset stands in for the erased state of a fresh part
    always_ff @(posedge clk) begin
        if (reset) begin
            s_r.mem <= {ARRAY_BYTES{ERASED}};
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : eeprom_array
`default_nettype wire

// file: hw/eeprom_pkg.sv
package eeprom_pkg;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SIZE_2K  = 2'h0,
        SIZE_4K  = 2'h1,
        SIZE_8K  = 2'h2,
        SIZE_16K = 2'h3
    } size_e;

    localparam int         ADDR_W      = 11;
    localparam int         DATA_W      = 8;
    localparam int         ENTRY_W     = ADDR_W + DATA_W;
    localparam int         FIFO_DEPTH  = 16;
    localparam int         ARRAY_BYTES = 2048;
    localparam logic [7:0] ERASED      = 8'hff;

    // ----------------------------------------------------------------
    // protocol constants
    // ----------------------------------------------------------------
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam logic [3:0] CNT_ACK  = 4'h8;
    localparam logic [3:0] CNT_END  = 4'h9;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 5;
    localparam int WRITE_CYCLE_MS   = 5;
    localparam int NS_PER_MS        = 1000000;
    localparam int WRITE_CYCLES_DEF = WRITE_CYCLE_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int TIMER_W          = 24;

    // ----------------------------------------------------------------
    // per-size masks
    // ----------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] addr_mask(input size_e sz);
        case (sz)
            SIZE_2K: addr_mask = 11'h0ff;
            SIZE_4K: addr_mask = 11'h1ff;
            SIZE_8K: addr_mask = 11'h3ff;
            default: addr_mask = 11'h7ff;
        endcase
    endfunction : addr_mask

    function automatic logic [ADDR_W-1:0] page_mask(input size_e sz);
        page_mask = (sz == SIZE_2K) ? 11'h007 : 11'h00f;
    endfunction : page_mask

    function automatic logic [2:0] sel_mask(input size_e sz);
        case (sz)
            SIZE_2K: sel_mask = 3'h7;
            SIZE_4K: sel_mask = 3'h6;
            SIZE_8K: sel_mask = 3'h4;
            default: sel_mask = 3'h0;
        endcase
    endfunction : sel_mask

    // ----------------------------------------------------------------
    // protocol states
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_DEV   = 6'h02,
        ST_WADDR = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_BUSY  = 6'h20
    } st_e;

endpackage : eeprom_pkg

// file: hw/serial_eeprom_target.sv
// Notes on behaviour
// RQ1: every start must be followed by an eight-bit device word before any operation
// RQ2: top four device-word bits must be the fixed one-zero pattern
// RQ3: 2K size compares three select bits with the three select pins
// RQ4: 4K size compares top two select bits; third is a page bit
// RQ5: 8K size compares top select bit; next two are page bits
// RQ6: 16K size compares no select bits; one device per bus
// RQ7: eighth device-word bit one means read, zero means write
// RQ8: matching device word gets an ack low; mismatch returns to standby
// RQ9: byte write is word address then one data byte, each acked, then stop
// RQ10: stop after write starts self-timed cycle; inputs ignored until done
// RQ11: page writes hold up to 8 bytes (2K) or 16 bytes (others)
// RQ12: further data bytes after the first are each acked low
// RQ13: write increments only low page bits; address wraps within the page
// RQ14: polling device word is acked only after the write cycle ends
// RQ15: current, random and sequential reads start with read bit one
// RQ16: word counter holds last accessed address plus one, kept across operations
// RQ17: read address wraps from last byte of array to first
// RQ18: current read acks device word then shifts out byte at counter
// RQ19: master loads address for random read by dummy write then repeated start
// RQ20: master ack advances address and sends next byte; no ack ends read
// RQ21: words are eight bits, the receiver acks low on the ninth clock
// RQ22: data changes with clock low; high-clock fall is start, rise is stop
// RQ23: self-timed write cycle lasts no longer than 5 ms after the stop
// RQ24: 16K size uses three select-position bits as high page address bits
// RQ25: data line released unless acking or shifting out read data
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_target #(
    parameter eeprom_pkg::size_e SIZE         = eeprom_pkg::SIZE_2K,
    parameter int                WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEF
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // two-wire bus
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // hard-wired select pins
    input  wire logic select_pin_high,
    input  wire logic select_pin_mid,
    input  wire logic select_pin_low,
    // status
    output logic      write_busy
);
    import eeprom_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0]         sync0;
        logic [4:0]         sync1;
        logic               scl_d;
        logic               sda_d;
        st_e                st;
        logic [3:0]         cnt;
        logic [7:0]         sh;
        logic [2:0]         pg;
        logic               rw;
        logic [ADDR_W-1:0]  addr;
        logic               oe;
        logic               sda_low;
        logic               push_pend;
        logic [ENTRY_W-1:0] push_data;
        logic               flush;
        logic [TIMER_W-1:0] timer;
        logic               busy;
    } ctl_s;

    // bus sync stages start at the idle level, so release shows no false edge
    localparam ctl_s CTL_RST = '{st: ST_IDLE, sync0: 5'h18, sync1: 5'h18,
                                 scl_d: 1'b1, sda_d: 1'b1, default: '0};
    localparam logic [ADDR_W-1:0] AMASK = addr_mask(SIZE);
    localparam logic [ADDR_W-1:0] PMASK = page_mask(SIZE);
    localparam logic [2:0]        SMASK = sel_mask(SIZE);

    ctl_s              s_r;
    ctl_s              s_nxt;
    logic              scl;
    logic              sda;
    logic [2:0]        pins;
    logic              rise;
    logic              fall;
    logic              start_c;
    logic              stop_c;
    logic              dev_match;
    logic              rx_state;
    logic [DATA_W-1:0] rd_byte;
    logic              commit;
    logic [ADDR_W-1:0] rd_next;
    logic [ADDR_W-1:0] wr_next;

    stream_if #(.WIDTH(ENTRY_W)) fill_s ();
    stream_if #(.WIDTH(ENTRY_W)) drain_s ();

    // ----------------------------------------------------------------
    // storage and write queue
    // ----------------------------------------------------------------
    stream_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .reset (reset),
        .in_s  (fill_s),
        .out_s (drain_s)
    );

    eeprom_array u_array (
        .clk   (clk),
        .reset (reset),
        .we    (commit),
        .waddr (drain_s.data[ENTRY_W-1:DATA_W]),
        .wdata (drain_s.data[DATA_W-1:0]),
        .raddr (s_r.addr),
        .rdata (rd_byte)
    );

    // queue commits only inside the write cycle, so an open page really fills
    assign commit         = s_r.busy & drain_s.valid; // RQ10
    assign fill_s.valid   = s_r.push_pend;
    assign fill_s.data    = s_r.push_data;
    // when full the oldest entry shares the new byte's page slot, so drop it
    assign drain_s.ready  = s_r.busy | s_r.flush | (s_r.push_pend & ~fill_s.ready); // RQ13

    // ----------------------------------------------------------------
    // bus conditions, seen only through the second sync stage
    // ----------------------------------------------------------------
    assign scl     = s_r.sync1[4];
    assign sda     = s_r.sync1[3];
    assign pins    = s_r.sync1[2:0];
    assign rise    = scl & ~s_r.scl_d;
    assign fall    = ~scl & s_r.scl_d;
    assign start_c = scl & s_r.scl_d & s_r.sda_d & ~sda; // RQ22
    assign stop_c  = scl & s_r.scl_d & ~s_r.sda_d & sda; // RQ22

    // unused select positions are masked out per size
    assign dev_match = (s_r.sh[7:4] == DEV_TYPE) // RQ2
                     && (((s_r.sh[3:1] ^ pins) & SMASK) == 3'h0); // RQ3 RQ4 RQ5 RQ6
    assign rx_state  = (s_r.st == ST_DEV) || (s_r.st == ST_WADDR) || (s_r.st == ST_WDATA);
    assign rd_next   = (s_r.addr + 11'h001) & AMASK; // RQ17
    assign wr_next   = (s_r.addr & ~PMASK) | ((s_r.addr + 11'h001) & PMASK); // RQ13

    // ----------------------------------------------------------------
    // protocol engine
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync0 = {scl_in, sda_in, select_pin_high, select_pin_mid, select_pin_low};
        s_nxt.sync1 = s_r.sync0;
        s_nxt.scl_d = scl;
        s_nxt.sda_d = sda;
        if (s_r.push_pend && fill_s.ready) begin
            s_nxt.push_pend = 1'b0;
        end
        if (s_r.flush && !drain_s.valid) begin
            s_nxt.flush = 1'b0;
        end
        case (s_r.st)
            ST_BUSY: begin
                // bus ignored entirely, so polling words go unanswered
                s_nxt.oe = 1'b0; // RQ10 RQ14
                if (s_r.timer != '0) begin
                    s_nxt.timer = s_r.timer - 1'b1; // RQ23
                end else if (!drain_s.valid) begin
                    s_nxt.st   = ST_IDLE;
                    s_nxt.busy = 1'b0;
                end
            end
            default: begin
                if (start_c) begin
                    s_nxt.st  = ST_DEV; // RQ1
                    s_nxt.cnt = 4'h0;
                    s_nxt.oe  = 1'b0;
                    // a repeated start abandons bytes not closed by a stop
                    if (drain_s.valid) begin
                        s_nxt.flush = 1'b1;
                    end
                end else if (stop_c) begin
                    s_nxt.oe  = 1'b0;
                    s_nxt.cnt = 4'h0;
                    if (drain_s.valid && !s_r.flush) begin
                        s_nxt.st    = ST_BUSY; // RQ10
                        s_nxt.busy  = 1'b1;
                        s_nxt.timer = TIMER_W'(WRITE_CYCLES - 1); // RQ23
                    end else begin
                        s_nxt.st = ST_IDLE;
                    end
                end else begin
                    case (s_r.st)
                        ST_DEV, ST_WADDR, ST_WDATA: begin
                            if (rise && s_r.cnt < CNT_ACK) begin
                                s_nxt.sh  = {s_r.sh[6:0], sda}; // RQ21
                                s_nxt.cnt = s_r.cnt + 4'h1;
                            end else if (rise && s_r.cnt == CNT_ACK) begin
                                s_nxt.cnt = CNT_END;
                            end else if (fall && s_r.cnt == CNT_ACK) begin
                                if (s_r.st == ST_DEV) begin
                                    if (dev_match) begin
                                        s_nxt.oe = 1'b1; // RQ8 RQ21
                                        s_nxt.rw = s_r.sh[0]; // RQ7
                                        s_nxt.pg = s_r.sh[3:1]; // RQ24
                                    end else begin
                                        s_nxt.st = ST_IDLE; // RQ8
                                    end
                                end else if (s_r.st == ST_WADDR) begin
                                    s_nxt.oe   = 1'b1; // RQ9
                                    s_nxt.addr = {s_r.pg, s_r.sh} & AMASK; // RQ4 RQ5 RQ24
                                end else begin
                                    s_nxt.oe        = 1'b1; // RQ9 RQ12
                                    s_nxt.push_pend = 1'b1; // RQ11
                                    s_nxt.push_data = {s_r.addr, s_r.sh};
                                    s_nxt.addr      = wr_next; // RQ13 RQ16
                                end
                            end else if (fall && s_r.cnt == CNT_END) begin
                                s_nxt.oe  = 1'b0; // RQ25
                                s_nxt.cnt = 4'h0;
                                if (s_r.st == ST_DEV && s_r.rw) begin
                                    s_nxt.st = ST_RDATA; // RQ15 RQ18
                                    s_nxt.sh = rd_byte;
                                    s_nxt.oe = ~rd_byte[7];
                                end else if (s_r.st == ST_DEV) begin
                                    s_nxt.st = ST_WADDR; // RQ9
                                end else begin
                                    s_nxt.st = ST_WDATA; // RQ12
                                end
                            end
                        end
                        ST_RDATA: begin
                            if (rise && s_r.cnt < CNT_ACK) begin
                                s_nxt.cnt = s_r.cnt + 4'h1;
                                if (s_r.cnt == CNT_ACK - 4'h1) begin
                                    s_nxt.addr = rd_next; // RQ16 RQ17
                                end
                            end else if (rise && s_r.cnt == CNT_ACK) begin
                                if (!sda) begin
                                    s_nxt.cnt = CNT_END; // RQ20
                                end else begin
                                    s_nxt.st = ST_IDLE; // RQ18 RQ20
                                end
                            end else if (fall && s_r.cnt != 4'h0 && s_r.cnt < CNT_ACK) begin
                                s_nxt.sh = {s_r.sh[6:0], 1'b0};
                                s_nxt.oe = ~s_r.sh[6];
                            end else if (fall && s_r.cnt == CNT_ACK) begin
                                s_nxt.oe = 1'b0; // RQ25
                            end else if (fall && s_r.cnt == CNT_END) begin
                                s_nxt.sh  = rd_byte; // RQ20
                                s_nxt.oe  = ~rd_byte[7];
                                s_nxt.cnt = 4'h0;
                            end
                        end
                        default: begin
                            s_nxt.oe = 1'b0; // RQ25
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= CTL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign sda_out    = s_r.sda_low;
    assign sda_oe     = s_r.oe;
    assign write_busy = s_r.busy;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_START_TO_DEV: assert property (@(posedge clk) disable iff (reset) // RQ1
        (start_c && s_r.st != ST_BUSY) |=> (s_r.st == ST_DEV && s_r.cnt == 4'h0))
        else $error("start did not open a device word");

    AST_MATCH_ACK: assert property (@(posedge clk) disable iff (reset) // RQ8
        (s_r.st == ST_DEV && fall && s_r.cnt == 4'h8 && dev_match && !start_c && !stop_c)
        |=> s_r.oe ##1 (s_r.oe || $past(fall)))
        else $error("matching device word not acknowledged");

    AST_MISMATCH_IDLE: assert property (@(posedge clk) disable iff (reset) // RQ8
        (s_r.st == ST_DEV && fall && s_r.cnt == 4'h8 && !dev_match && !start_c && !stop_c)
        |=> (!s_r.oe && s_r.st == ST_IDLE))
        else $error("mismatched device word was not dropped");

    AST_BUSY_SILENT: assert property (@(posedge clk) disable iff (reset) // RQ10
        $past(s_r.st) == ST_BUSY |-> !s_r.oe)
        else $error("data line driven during write cycle");

    AST_STOP_BUSY: assert property (@(posedge clk) disable iff (reset) // RQ10
        (s_r.st == ST_WDATA && stop_c && drain_s.valid && !s_r.flush)
        |=> (s_r.busy && s_r.timer == TIMER_W'(WRITE_CYCLES - 1)))
        else $error("stop after data did not start the write cycle");

    AST_PAGE_WRAP: assert property (@(posedge clk) disable iff (reset) // RQ13
        (s_r.st == ST_WDATA && fall && s_r.cnt == 4'h8 && !start_c && !stop_c)
        |=> ((s_r.addr & ~PMASK) == ($past(s_r.addr) & ~PMASK))
            && ((s_r.addr & PMASK) == (($past(s_r.addr) + 11'h001) & PMASK)))
        else $error("write address left its page");

    AST_READ_WRAP: assert property (@(posedge clk) disable iff (reset) // RQ17
        (s_r.st == ST_RDATA && rise && s_r.cnt == 4'h7 && !start_c && !stop_c)
        |=> s_r.addr == (($past(s_r.addr) + 11'h001) & AMASK))
        else $error("read address did not advance over the array");

    AST_IDLE_RELEASED: assert property (@(posedge clk) disable iff (reset) // RQ25
        (s_r.st == ST_IDLE && $past(s_r.st) == ST_IDLE) |-> !s_r.oe)
        else $error("data line held in standby");

    AST_ACK_NINTH: assert property (@(posedge clk) disable iff (reset) // RQ21
        ($rose(s_r.oe) && $past(rx_state)) |-> $past(s_r.cnt) == 4'h8)
        else $error("acknowledge outside the ninth clock");

    AST_RW_SELECT: assert property (@(posedge clk) disable iff (reset) // RQ7
        (s_r.st == ST_DEV && fall && s_r.cnt == 4'h9 && !start_c && !stop_c)
        |=> s_r.st == ($past(s_r.rw) ? ST_RDATA : ST_WADDR))
        else $error("operation bit chose the wrong path");

    AST_WRITE_END: assert property (@(posedge clk) disable iff (reset) // RQ23
        (s_r.st == ST_BUSY && s_r.timer == '0 && !drain_s.valid)
        |=> (s_r.st == ST_IDLE && !s_r.busy))
        else $error("write cycle overran its time");

    AST_WADDR_LOAD: assert property (@(posedge clk) disable iff (reset) // RQ9
        (s_r.st == ST_WADDR && fall && s_r.cnt == 4'h8 && !start_c && !stop_c)
        |=> (s_r.addr[7:0] == $past(s_r.sh)) && ((s_r.addr & ~AMASK) == 11'h000))
        else $error("word address not loaded into the counter");

    AST_NACK_STANDBY: assert property (@(posedge clk) disable iff (reset) // RQ20
        (s_r.st == ST_RDATA && rise && s_r.cnt == 4'h8 && sda && !start_c && !stop_c)
        |=> (s_r.st == ST_IDLE && !s_r.oe))
        else $error("read went on after a missing acknowledge");

endmodule : serial_eeprom_target
`default_nettype wire

// file: hw/stream_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fill and drain sides
    stream_if.snk    in_s,
    stream_if.src    out_s
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wp;
        logic [PTR_W-1:0]            rp;
        logic [PTR_W:0]              cnt;
    } fifo_s;

    fifo_s s_r;
    fifo_s s_nxt;
    logic  push;
    logic  pop;

    // ready does not look at pop, so no path runs from drain to fill side
    assign in_s.ready = (s_r.cnt != (PTR_W+1)'(DEPTH));
    assign out_s.valid = (s_r.cnt != '0);
    assign out_s.data  = s_r.mem[s_r.rp];
    assign push = in_s.valid & in_s.ready;
    assign pop  = out_s.valid & out_s.ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_s.data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : stream_fifo
`default_nettype wire

// file: hw/stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire
